// ### verilog/cild_params.svh
// Constants of the camera control-line block: register offsets, field
// positions, reset values and timing figures.
// Assumes a 25 MHz register clock and 32-bit APB data.
`ifndef CILD_PARAMS_SVH
`define CILD_PARAMS_SVH

`define CILD_CLK_HZ 25000000
`define CILD_NS_PER_S 1000000000
`define CILD_CLK_PERIOD_NS (`CILD_NS_PER_S / `CILD_CLK_HZ)

`define CILD_DEBOUNCE_DEF_NS 500
`define CILD_DEBOUNCE_MAX_US 1000000
`define CILD_DEBOUNCE_MAX_NS (`CILD_DEBOUNCE_MAX_US * 1000)
`define CILD_NS_W 30

`define CILD_ADDR_W 8
`define CILD_OFF_CTRL 8'h00
`define CILD_OFF_DEBOUNCE 8'h04
`define CILD_OFF_STATUS 8'h08
`define CILD_OFF_USER 8'h0c

`define CILD_CTRL_IN_DIR 0
`define CILD_CTRL_OUT_DIR 1
`define CILD_CTRL_FLIP 2
`define CILD_CTRL_SRC_LO 4
`define CILD_CTRL_SRC_HI 6
`define CILD_CTRL_PICK 8

`define CILD_USER_LEVEL 0

`define CILD_ST_FILT 0
`define CILD_ST_SYNC 1
`define CILD_ST_OUT 2
`define CILD_ST_OE 3
`define CILD_ST_EXP 4
`define CILD_ST_READ 5
`define CILD_ST_TIMER 6
`define CILD_ST_PICKED 8

`define CILD_RST_IN_DIR 1'b0
`define CILD_RST_OUT_DIR 1'b1
`define CILD_RST_FLIP 1'b0
`define CILD_RST_SRC 3'h0
`define CILD_RST_PICK 1'b0
`define CILD_RST_LEVEL 1'b0

`endif

// ### verilog/cild_pkg.sv
// Types shared by the camera control-line block.
// Assumes cild_params.svh holds every number these types meet.
package cild_pkg;

	// Encoding of the output source field, in this order from zero.
	typedef enum logic [2:0] {
		CILD_SRC_OFF,
		CILD_SRC_EXPOSURE,
		CILD_SRC_READOUT,
		CILD_SRC_SOFTWARE,
		CILD_SRC_TIMER
	} cild_src_t;

	// Phases of an APB transfer as seen by the slave.
	typedef enum logic [1:0] {
		CILD_APB_IDLE,
		CILD_APB_WAIT,
		CILD_APB_DONE
	} cild_apb_t;

endpackage

// ### verilog/cild_debounce.sv
// Input synchroniser and glitch filter for the input terminal.
// Assumes the raw pin is asynchronous and the interval is held steady
// by the register file; interval is in nanoseconds.
`timescale 1ns/1ps
`include "cild_params.svh"

module cild_debounce #(
	parameter int NS_W = `CILD_NS_W,
	parameter int PERIOD_NS = `CILD_CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic raw_in,
	input wire logic [NS_W-1:0] interval_ns,
	output logic sync_level,
	output logic filtered
);

	generate
		if (PERIOD_NS < 1 || NS_W < 2 || PERIOD_NS >= (1 << (NS_W - 1))) begin
			$error("cild_debounce: clock period does not fit the counter");
		end
	endgenerate

	localparam logic [NS_W-1:0] STEP = NS_W'(PERIOD_NS);

	logic meta_q;
	logic sync_q;
	logic filt_q;
	logic [NS_W-1:0] elapsed_q;
	logic [NS_W:0] elapsed_next;

	assign sync_level = sync_q;
	assign filtered = filt_q;
	assign elapsed_next = {1'b0, elapsed_q} + {1'b0, STEP};

	// Two flops before anything looks at the pin.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= raw_in;
			sync_q <= meta_q;
		end
	end

	// Elapsed time counts in nanoseconds at one clock period per edge, so
	// the accepted stable time rounds up to whole cycles.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_q <= 1'b0;
			elapsed_q <= '0;
		end else if (!enable) begin
			filt_q <= 1'b0;
			elapsed_q <= '0;
		end else if (interval_ns == '0) begin
			filt_q <= sync_q;
			elapsed_q <= '0;
		end else if (sync_q == filt_q) begin
			// A level that falls back before the interval is discarded.
			elapsed_q <= '0;
		end else if (elapsed_next >= {1'b0, interval_ns}) begin
			// Accepted only after the full interval, which is the latency.
			filt_q <= sync_q;
			elapsed_q <= '0;
		end else begin
			elapsed_q <= elapsed_next[NS_W-1:0];
		end
	end

endmodule

// ### verilog/cild_top.sv
// Control-line block of the camera: one debounced input terminal, one
// output terminal with a selectable source, registers over APB.
// Assumes exposure, readout and timer levels arrive synchronous to pclk
// from the sensor timing logic and the timer generator.
//
// Contract
// - Input terminal acts as input in input mode
// - Output terminal drives only in output mode
// - Inversion flag complements the selected source
// - Source off leaves output terminal undriven
// - Exposure source shows the exposure window
// - Readout source shows the readout window
// - Software source follows the user bit
// - User bit false low, true high
// - Timer source copies timer zero pulse
// - Exposure signal spans exposure start to end
// - Input accepted after stable debounce time
// - Shorter highs or lows are discarded
// - Valid edge delayed by debounce time
// - Debounce time zero to maximum, default half microsecond
`timescale 1ns/1ps
`include "cild_params.svh"

module cild_top
	import cild_pkg::*;
#(
	parameter int ADDR_W = `CILD_ADDR_W,
	parameter int NS_W = `CILD_NS_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic input_terminal_pin,
	input wire logic exposure_window_signal,
	input wire logic readout_window_signal,
	input wire logic timer_pulse_source,
	output logic input_terminal_level,
	output logic output_terminal_o,
	output logic output_terminal_oe
);

	generate
		if (ADDR_W < 4 || ADDR_W > 32) begin
			$error("cild_top: address width out of range");
		end
		if (NS_W < 30 || NS_W > 31) begin
			$error("cild_top: debounce counter cannot hold the maximum");
		end
	endgenerate

	localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(`CILD_OFF_CTRL);
	localparam logic [ADDR_W-1:0] A_DEBOUNCE = ADDR_W'(`CILD_OFF_DEBOUNCE);
	localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(`CILD_OFF_STATUS);
	localparam logic [ADDR_W-1:0] A_USER = ADDR_W'(`CILD_OFF_USER);
	localparam logic [NS_W-1:0] DEB_DEF = NS_W'(`CILD_DEBOUNCE_DEF_NS);
	localparam logic [NS_W-1:0] DEB_MAX = NS_W'(`CILD_DEBOUNCE_MAX_NS);

	// Control fields.
	logic in_dir_q;
	logic out_dir_q;
	logic flip_q;
	logic [2:0] src_q;
	logic pick_q;
	logic level_q;
	logic [NS_W-1:0] debounce_q;

	// Output terminal flops.
	logic out_q;
	logic oe_q;

	// Bus answer flops.
	cild_apb_t apb_q;
	cild_apb_t apb_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic err_q;
	logic err_d;
	logic ready_q;

	// Filter taps.
	logic sync_level;
	logic filt_level;

	// Decoded access.
	logic hit_ctrl;
	logic hit_debounce;
	logic hit_status;
	logic hit_user;
	logic mapped;
	logic wr_fire;
	logic [31:0] wr_mask;
	logic [31:0] wr_ctrl;
	logic [31:0] wr_user;
	logic [31:0] wr_deb;
	logic [NS_W-1:0] deb_clamped;

	// Output source resolution.
	logic src_level;
	logic drive_en;

	// Register images.
	logic [31:0] img_ctrl;
	logic [31:0] img_status;
	logic [31:0] img_user;
	logic [31:0] img_debounce;

	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;
	assign input_terminal_level = filt_level;
	assign output_terminal_o = out_q;
	assign output_terminal_oe = oe_q;

	// Address decode.
	always_comb begin
		hit_ctrl = 1'b0;
		hit_debounce = 1'b0;
		hit_status = 1'b0;
		hit_user = 1'b0;
		if (paddr == A_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (paddr == A_DEBOUNCE) begin
			hit_debounce = 1'b1;
		end else if (paddr == A_STATUS) begin
			hit_status = 1'b1;
		end else if (paddr == A_USER) begin
			hit_user = 1'b1;
		end
		mapped = hit_ctrl | hit_debounce | hit_status | hit_user;
	end

	// Byte lanes select which bits a write replaces.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wr_mask[gi*8 +: 8] = {8{pstrb[gi]}};
		end
	endgenerate

	assign wr_ctrl = (img_ctrl & ~wr_mask) | (pwdata & wr_mask);
	assign wr_user = (img_user & ~wr_mask) | (pwdata & wr_mask);
	assign wr_deb = (img_debounce & ~wr_mask) | (pwdata & wr_mask);

	// Writes beyond the longest interval are held at the longest one.
	assign deb_clamped = (wr_deb > 32'(DEB_MAX)) ? DEB_MAX : wr_deb[NS_W-1:0];

	// A write lands on the edge that completes the access phase.
	assign wr_fire = psel & penable & pwrite & (apb_q == CILD_APB_DONE) &
		mapped;

	// Two wait states: ready comes on the third access cycle.
	always_comb begin
		apb_d = apb_q;
		case (apb_q)
			CILD_APB_IDLE: begin
				if (psel && penable) begin
					apb_d = CILD_APB_WAIT;
				end
			end
			CILD_APB_WAIT: begin
				apb_d = CILD_APB_DONE;
			end
			CILD_APB_DONE: begin
				apb_d = CILD_APB_IDLE;
			end
			default: begin
				apb_d = CILD_APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_q <= CILD_APB_IDLE;
		end else begin
			apb_q <= apb_d;
		end
	end

	// Ready is a flop of its own so the bus never sees a decode glitch; it
	// rises with the done state and stands for that one cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= (apb_d == CILD_APB_DONE);
		end
	end

	// Read data and error are formed one cycle before ready and stand with
	// it; unmapped addresses answer zero with an error.
	always_comb begin
		rdata_d = rdata_q;
		err_d = err_q;
		if (apb_q == CILD_APB_WAIT) begin
			err_d = ~mapped;
			rdata_d = 32'h0000_0000;
			if (!pwrite) begin
				if (hit_ctrl) begin
					rdata_d = img_ctrl;
				end else if (hit_debounce) begin
					rdata_d = img_debounce;
				end else if (hit_status) begin
					rdata_d = img_status;
				end else if (hit_user) begin
					rdata_d = img_user;
				end
			end
		end else if (apb_q == CILD_APB_DONE) begin
			rdata_d = 32'h0000_0000;
			err_d = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// Register images; unused bits read as zero.
	always_comb begin
		img_ctrl = 32'h0000_0000;
		img_ctrl[`CILD_CTRL_IN_DIR] = in_dir_q;
		img_ctrl[`CILD_CTRL_OUT_DIR] = out_dir_q;
		img_ctrl[`CILD_CTRL_FLIP] = flip_q;
		img_ctrl[`CILD_CTRL_SRC_HI:`CILD_CTRL_SRC_LO] = src_q;
		img_ctrl[`CILD_CTRL_PICK] = pick_q;
		img_user = 32'h0000_0000;
		img_user[`CILD_USER_LEVEL] = level_q;
		img_debounce = 32'(debounce_q);
		img_status = 32'h0000_0000;
		img_status[`CILD_ST_FILT] = filt_level;
		img_status[`CILD_ST_SYNC] = sync_level;
		img_status[`CILD_ST_OUT] = out_q;
		img_status[`CILD_ST_OE] = oe_q;
		img_status[`CILD_ST_EXP] = exposure_window_signal;
		img_status[`CILD_ST_READ] = readout_window_signal;
		img_status[`CILD_ST_TIMER] = timer_pulse_source;
		img_status[`CILD_ST_PICKED] = pick_q ? out_q : filt_level;
	end

	// Control register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_dir_q <= `CILD_RST_IN_DIR;
			out_dir_q <= `CILD_RST_OUT_DIR;
			flip_q <= `CILD_RST_FLIP;
			src_q <= `CILD_RST_SRC;
			pick_q <= `CILD_RST_PICK;
		end else if (wr_fire && hit_ctrl) begin
			in_dir_q <= wr_ctrl[`CILD_CTRL_IN_DIR];
			out_dir_q <= wr_ctrl[`CILD_CTRL_OUT_DIR];
			flip_q <= wr_ctrl[`CILD_CTRL_FLIP];
			src_q <= wr_ctrl[`CILD_CTRL_SRC_HI:`CILD_CTRL_SRC_LO];
			pick_q <= wr_ctrl[`CILD_CTRL_PICK];
		end
	end

	// User output bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= `CILD_RST_LEVEL;
		end else if (wr_fire && hit_user) begin
			level_q <= wr_user[`CILD_USER_LEVEL];
		end
	end

	// Debounce interval in nanoseconds, half a microsecond after reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			debounce_q <= DEB_DEF;
		end else if (wr_fire && hit_debounce) begin
			debounce_q <= deb_clamped;
		end
	end

	// The filter runs only while the input terminal is in input mode; in
	// the other mode internal logic sees a steady low.
	cild_debounce #(
		.NS_W(NS_W),
		.PERIOD_NS(`CILD_CLK_PERIOD_NS)
	) u_filter (
		.clk(pclk),
		.rst_n(presetn),
		.enable(~in_dir_q),
		.raw_in(input_terminal_pin),
		.interval_ns(debounce_q),
		.sync_level(sync_level),
		.filtered(filt_level)
	);

	// Source selection. Codes past the last source count as off, so a
	// stray write cannot start driving the line.
	always_comb begin
		src_level = 1'b0;
		drive_en = 1'b1;
		case (src_q)
			CILD_SRC_EXPOSURE: begin
				src_level = exposure_window_signal;
			end
			CILD_SRC_READOUT: begin
				src_level = readout_window_signal;
			end
			CILD_SRC_SOFTWARE: begin
				src_level = level_q;
			end
			CILD_SRC_TIMER: begin
				src_level = timer_pulse_source;
			end
			default: begin
				drive_en = 1'b0;
			end
		endcase
	end

	// The pin is registered so it never glitches while the source field
	// is rewritten; this costs one cycle of delay on every source.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (out_dir_q && drive_en) begin
			out_q <= src_level ^ flip_q;
			oe_q <= 1'b1;
		end else begin
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end
	end

endmodule

// ### testbench/cild_top_props.sv
// Checker of the control-line block, bound to every cild_top.
// Assumes two wait states on APB and sources synchronous to pclk.
`timescale 1ns/1ps
module cild_top_props #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic input_terminal_pin,
	input wire logic exposure_window_signal,
	input wire logic readout_window_signal,
	input wire logic timer_pulse_source,
	input wire logic input_terminal_level,
	input wire logic output_terminal_o,
	input wire logic output_terminal_oe
);
	wire logic [2:0] srcs = {exposure_window_signal,
		readout_window_signal, timer_pulse_source};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence apb_access;
		psel && !penable ##1 psel && penable;
	endsequence
	chk_ready_wait: assert property (apb_access |=> !pready ##1 pready)
		else $error("pready missing after access");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("pslverr out of place");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero while idle");
	chk_off_quiet: assert property (!output_terminal_oe |-> !output_terminal_o)
		else $error("undriven line shows a level");
	chk_filter_lag: assert property ($changed(input_terminal_level) |->
		$past(input_terminal_pin, 3) == input_terminal_level)
		else $error("filtered level moved too early");
	// A source edge or a register write is the only cause of a pin change.
	chk_out_cause: assert property ($changed(output_terminal_o) |->
		$past(srcs) != $past(srcs, 2) || $past(pready && pwrite, 2))
		else $error("output moved without cause");
	chk_oe_cause: assert property ($changed(output_terminal_oe) |->
		$past(pready && pwrite, 2))
		else $error("enable moved without a write");
endmodule
bind cild_top cild_top_props #(.ADDR_W(ADDR_W)) chk_u (.*);

// ### testbench/cild_line_partner.sv
// Trigger source and strobe load on the control terminal.
// Assumes pclk paces the trigger; the strobe line has a pull-down.
`timescale 1ns/1ps
module cild_line_partner (
	input wire logic pclk,
	input wire logic line_o,
	input wire logic line_oe,
	output logic trig_pin,
	output logic strobe_seen
);
	initial trig_pin = 1'b0;
	// An undriven strobe line rests at its pull-down level.
	assign strobe_seen = line_oe ? line_o : 1'b0;
	task set_level(input logic v);
		@(posedge pclk);
		trig_pin <= v;
	endtask
	task glitch(input int n);
		logic v;
		v = trig_pin;
		set_level(!v);
		repeat (n - 1) @(posedge pclk);
		set_level(v);
	endtask
endmodule

// ### testbench/test_camera_io_line_debounce.sv
// Self-checking bench of the control-line block.
// Assumes the checker and the line partner are compiled before it.
`timescale 1ns/1ps
module test_camera_io_line_debounce;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin;
	logic [2:0] srcs = 3'h0;
	logic level;
	logic out_o;
	logic out_oe;
	logic seen;
	logic [31:0] lfsr = 32'h6d1f;
	logic [32:0] exp_q[$];
	int errors = 0;
	int checks = 0;
	always #20 pclk = ~pclk;
	cild_top dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.input_terminal_pin(pin), .exposure_window_signal(srcs[2]),
		.readout_window_signal(srcs[1]), .timer_pulse_source(srcs[0]),
		.input_terminal_level(level), .output_terminal_o(out_o),
		.output_terminal_oe(out_oe)
	);
	cild_line_partner part_u (
		.pclk(pclk), .line_o(out_o), .line_oe(out_oe),
		.trig_pin(pin), .strobe_seen(seen)
	);
	function logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk);
		while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask
	task rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task complete_run();
		if (exp_q.size() != 0)
			errors++;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
			chk("read", exp_q.pop_front(), {pslverr, prdata});
	end
	// The whole sequence needs about three hundred and fifty cycles.
	initial begin
		#400000;
		errors++;
		complete_run();
	end
	initial begin
		int s;
		int f;
		int k;
		logic [31:0] x;
		logic e;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 33'h2);
		rd(8'h04, 33'h1f4);
		rd(8'h0c, 33'h0);
		rd(8'h10, 33'h100000000);
		chk("oe", 0, out_oe);
		apb(1'b1, 8'h04, 32'h77359400);
		rd(8'h04, 33'h3b9aca00);
		for (s = 0; s < 5; s++) begin
			for (f = 0; f < 4; f++) begin
				x = rnd();
				@(posedge pclk);
				srcs <= x[2:0];
				apb(1'b1, 8'h0c, {31'h0, x[3]});
				apb(1'b1, 8'h00, {25'h0, s[2:0], 1'b0, f[0], 2'b10});
				repeat (2) @(posedge pclk);
				#1;
				chk("oe", s != 0, out_oe);
				e = s == 1 ? x[2] : s == 2 ? x[1] : s == 3 ? x[3] : x[0];
				chk("line", (s != 0) & (e ^ f[0]), seen);
			end
		end
		rd(8'h08, {26'h0, x[0], x[1], x[2], 1'b1, ~x[0], 2'b00});
		apb(1'b1, 8'h00, 32'h142);
		rd(8'h08, {24'h0, x[0], 1'b0, x[0], x[1], x[2], 1'b1, x[0], 2'b00});
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b1, 8'h04, 32'h50);
		part_u.glitch(1);
		repeat (8) @(posedge pclk);
		#1;
		chk("glitch", 0, level);
		// Two sync flops, then two 40 ns steps to cover the 80 ns interval.
		part_u.set_level(1'b1);
		for (k = 1; k <= 5; k++) begin
			@(posedge pclk);
			#1;
			chk("lag", k >= 4, level);
		end
		apb(1'b1, 8'h04, 32'h0);
		part_u.set_level(1'b0);
		for (k = 1; k <= 3; k++) begin
			@(posedge pclk);
			#1;
			chk("direct", k != 3, level);
		end
		complete_run();
	end
endmodule
